// >>> pcs_defs.vh
// Operation
// [RL1] power_down_n low holds power-down with PLL and oscillator enables off
// [RL2] power-down entry zeroes volume at once and forces hard mute
// [RL3] power-down entry is asynchronous, needs no running clock
// [RL4] controller runs clock at least five cycles before releasing power-down
// [RL5] in power-down valid, PWM P/M, supply volume control low; SDA undriven
// [RL6] I2C and serial audio transfers ignored while power-down held
// [RL7] power-down stops PWM at once; mute first for a quiet stop
// [RL8] after power-down, measure rates, then reach end state, unmute when known
// [RL9] backend_error_n is a level; error needs at least five low cycles
// [RL10] back-end error: error state, wait 5 ms, re-init, resume
// [RL11] during back-end error valid and speaker/headphone PWM low, SDA undriven
// [RL12] channel-count bit 0 puts all eight outputs in error state
// [RL13] six-channel error: valid low, outputs 1-4,7,8 error, 5 and 6 run
// [RL14] software writes lineout channel configurations to zero for six channels
// [RL15] headphone_select_n low enables headphone, high enables speakers
// [RL16] each headphone select change soft mutes all then soft unmutes
// [RL17] channels 1-2 use headphone config while select low, own when high
// [RL18] remapped mixer in six-channel mode: controller toggles mute after select
// [RL19] mute ramps volume to silence; release ramps back to previous volume
// [RL20] register mute or mute pin low mutes all channels
// [RL21] muted channel stops switching then goes idle
// [RL22] any mute source overrides unmute and volume; unmute restores last volume
// [RL23] back-end error, select and mute inputs pass two-stage synchronizers
`ifndef PCS_DEFS_VH
`define PCS_DEFS_VH
`define PCS_CLK_HZ       25000000
`define PCS_ERR_MIN_CYC  5
`define PCS_ERR_WAIT_US  5000
`define PCS_ERR_WAIT_CYC ((`PCS_ERR_WAIT_US * (`PCS_CLK_HZ / 1000)) / 1000)
`define PCS_RATE_CYC     64
`define PCS_REINIT_CYC   32
`define PCS_VOL_W        8
`define PCS_VOL_MAX      8'hFF
`define PCS_CH_N         8
`define PCS_LINEOUT_MASK 8'h30
`endif

// >>> pcs_pin_sequencer.v
`timescale 1ns/1ns
`include "pcs_defs.vh"
module pcs_pin_sequencer #(
    parameter ERR_WAIT_CYC = `PCS_ERR_WAIT_CYC,
    parameter RATE_CYC     = `PCS_RATE_CYC,
    parameter REINIT_CYC   = `PCS_REINIT_CYC,
    parameter VOL_STEP     = 1
) (
    // clock and reset
    input  wire       clk_sys,
    input  wire       rstn,
    // pins
    input  wire       power_down_n,
    input  wire       backend_error_n,
    input  wire       headphone_select_n,
    input  wire       mute_n,
    // configuration
    input  wire       six_channel,
    input  wire       reg_master_mute_n,
    input  wire [7:0] chan_mute,
    input  wire [7:0] volume_cmd,
    input  wire       supply_volume_control_enable,
    // status and control outputs
    output reg        valid,
    output reg        pll_osc_enable,
    output reg        bus_enable,
    output reg  [7:0] pwm_run,
    output reg  [1:0] hp_run,
    output reg  [7:0] volume,
    output reg        hp_config_sel,
    output reg        supply_volume_control,
    output reg        sda_oe,
    output reg        rates_known
);
    localparam S_PDN    = 6'h01;
    localparam S_RATE   = 6'h02;
    localparam S_RUN    = 6'h04;
    localparam S_ERR    = 6'h08;
    localparam S_REINIT = 6'h10;
    localparam S_HPSW   = 6'h20;

    // counter end points kept as integers so no bits are dropped in the compares
    localparam integer RATE_END   = RATE_CYC - 1;
    localparam integer ERR_END    = ERR_WAIT_CYC - 1;
    localparam integer REINIT_END = REINIT_CYC - 1;
    localparam integer ERR_MIN    = `PCS_ERR_MIN_CYC;
    localparam [7:0]   STEP       = VOL_STEP;

    // power-down pin acts as an extra async reset so no clock is needed
    wire arst_n = rstn & power_down_n; // [RL3]
    reg  rs1_q;
    reg  rs2_q;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end
    wire rst_n = rs2_q;

    // two-flop synchronisers, first stage read only by second
    genvar g;
    wire [2:0] sync_in = {mute_n, headphone_select_n, backend_error_n}; // [RL23]
    wire [2:0] sync_out;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_sync
            reg s1_q;
            reg s2_q;
            // idle level is high so leaving reset shows no false edge
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q <= 1'b1;
                    s2_q <= 1'b1;
                end else begin
                    s1_q <= sync_in[g]; // [RL23]
                    s2_q <= s1_q;
                end
            end
            assign sync_out[g] = s2_q;
        end
    endgenerate

    wire err_n_s = sync_out[0];
    wire hp_n_s  = sync_out[1];
    wire mute_s  = sync_out[2];

    reg [5:0]  st_q;
    reg [5:0]  st_d;
    reg [22:0] cnt_q;
    reg [22:0] cnt_d;
    reg [2:0]  low_q;
    reg [2:0]  low_d;
    reg        hp_prev_q;
    reg        hp_prev_d;
    reg [7:0]  vol_q;
    reg [7:0]  pwm_q;
    reg [1:0]  hp_q;
    wire [7:0] ch_idle;

    wire running = (st_q == S_RUN) | (st_q == S_HPSW);
    wire in_err  = (st_q == S_ERR) | (st_q == S_REINIT);

    // error only counts after five consecutive low samples; shorter dips are glitches
    wire err_hit = (low_q >= ERR_MIN); // [RL9]
    always @* begin
        low_d = low_q;
        if (err_n_s)
            low_d = 3'h0;
        else if (!err_hit)
            low_d = low_q + 3'h1;
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            low_q <= 3'h0;
        else
            low_q <= low_d;
    end

    // error mask: lineouts 5 and 6 keep running in six-channel mode
    wire [7:0] err_mask = six_channel ? ~`PCS_LINEOUT_MASK : 8'hFF; // [RL12] [RL13]
    // any mute source silences; pin or register master mute hits every channel
    wire       master_mute = ~mute_s | ~reg_master_mute_n; // [RL20]
    wire [7:0] ch_mute = chan_mute | {8{master_mute}}; // [RL22]
    wire       hp_chg = (hp_n_s != hp_prev_q); // [RL16]
    wire       silent = (vol_q == 8'h00);
    wire       muting = (st_q == S_HPSW) | master_mute; // [RL16] [RL22]
    wire [7:0] vol_tgt = muting ? 8'h00 : volume_cmd; // [RL19] [RL22]

    // hp_prev_q is the applied selection; it changes only at the end of S_RATE or once the swap is silent,
    // so a swap cut short by an error is taken up again after recovery
    always @* begin
        st_d      = st_q;
        cnt_d     = cnt_q;
        hp_prev_d = hp_prev_q;
        case (st_q)
            S_PDN: begin
                st_d  = S_RATE;
                cnt_d = 23'h0;
            end
            // measure clock rates against the crystal before unmuting
            S_RATE: begin
                cnt_d = cnt_q + 23'h1; // [RL8]
                if (cnt_q >= RATE_END) begin
                    st_d      = S_RUN;
                    cnt_d     = 23'h0;
                    hp_prev_d = hp_n_s;
                end
            end
            S_RUN: begin
                if (err_hit) begin
                    st_d  = S_ERR; // [RL10]
                    cnt_d = 23'h0;
                end else if (hp_chg) begin
                    st_d = S_HPSW; // [RL16]
                end
            end
            S_ERR: begin
                cnt_d = cnt_q + 23'h1;
                if (cnt_q >= ERR_END) begin
                    st_d  = S_REINIT; // [RL10]
                    cnt_d = 23'h0;
                end
            end
            // a level input: re-init waits until the error pin is released
            S_REINIT: begin
                if (!err_hit)
                    cnt_d = cnt_q + 23'h1;
                if (!err_hit && cnt_q >= REINIT_END) begin
                    st_d  = S_RUN; // [RL10]
                    cnt_d = 23'h0;
                end
            end
            S_HPSW: begin
                if (err_hit) begin
                    st_d  = S_ERR;
                    cnt_d = 23'h0;
                end else if (silent) begin
                    st_d      = S_RUN; // [RL16]
                    hp_prev_d = hp_n_s;
                end
            end
            default: begin
                st_d = S_PDN;
            end
        endcase
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_q      <= S_PDN;
            cnt_q     <= 23'h0;
            hp_prev_q <= 1'b1;
        end else begin
            st_q      <= st_d;
            cnt_q     <= cnt_d;
            hp_prev_q <= hp_prev_d;
        end
    end

    // volume ramps one step per clock; power-down reset forces it to zero
    // the ramp keeps going through a back-end error so lineouts are not disturbed
    // the last step lands on the target, so the ramp never overshoots
    wire [7:0] vol_up   = (vol_tgt - vol_q > STEP) ? vol_q + STEP : vol_tgt;
    wire [7:0] vol_down = (vol_q - vol_tgt > STEP) ? vol_q - STEP : vol_tgt;
    reg  [7:0] vol_d;
    always @* begin
        vol_d = vol_q;
        if (!running && !in_err)
            vol_d = 8'h00; // [RL2]
        else if (vol_q < vol_tgt)
            vol_d = vol_up; // [RL19]
        else if (vol_q > vol_tgt)
            vol_d = vol_down; // [RL19]
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            vol_q <= 8'h00; // [RL2]
        else
            vol_q <= vol_d;
    end

    // channel run enables; a muted channel stops only once its own ramp is silent
    // speakers and headphone both sit in hard mute for the cycle of the swap
    wire hp_hard = (st_q == S_HPSW) & silent; // [RL16]
    generate
        for (g = 0; g < `PCS_CH_N; g = g + 1) begin : g_ch
            // each channel ramps on its own so a chan_mute bit silences only that channel
            reg  [7:0] cv_q;
            reg  [7:0] cv_d;
            wire       err_off = in_err & err_mask[g]; // [RL11]
            wire       keep    = in_err & ~err_mask[g]; // [RL13]
            wire       spk_off = (g < 2) & (~hp_prev_q | hp_hard); // [RL15] [RL16]
            always @* begin
                cv_d = vol_q;
                if (ch_mute[g])
                    cv_d = (cv_q > STEP) ? cv_q - STEP : 8'h00; // [RL19] [RL22]
            end

            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n)
                    cv_q <= 8'h00;
                else
                    cv_q <= cv_d;
            end
            assign ch_idle[g] = ch_mute[g] & (cv_q == 8'h00); // [RL21]

            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n)
                    pwm_q[g] <= 1'b0; // [RL5] [RL7]
                else
                    pwm_q[g] <= (running | keep) & ~err_off & ~spk_off & ~ch_idle[g];
            end
        end
        for (g = 0; g < 2; g = g + 1) begin : g_hp
            always @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n)
                    hp_q[g] <= 1'b0;
                else
                    hp_q[g] <= running & ~hp_prev_q & ~hp_hard & ~ch_idle[g]; // [RL15]
            end
        end
    endgenerate

    // next values of the registered outputs
    wire valid_d  = running; // [RL11] [RL13]
    wire svc_d    = supply_volume_control_enable & running; // [RL5]
    wire known_d  = (st_q != S_PDN) & (st_q != S_RATE); // [RL8]
    wire hp_cfg_d = ~hp_prev_q; // [RL17]

    // registered outputs
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            valid                 <= 1'b0; // [RL5]
            pll_osc_enable        <= 1'b0; // [RL1]
            bus_enable            <= 1'b0; // [RL6]
            pwm_run               <= 8'h00;
            hp_run                <= 2'h0;
            volume                <= 8'h00;
            hp_config_sel         <= 1'b0;
            supply_volume_control <= 1'b0; // [RL5]
            sda_oe                <= 1'b0;
            rates_known           <= 1'b0;
        end else begin
            valid                 <= valid_d; // [RL11] [RL13]
            pll_osc_enable        <= 1'b1; // [RL1]
            bus_enable            <= 1'b1; // [RL6]
            pwm_run               <= pwm_q;
            hp_run                <= hp_q;
            volume                <= vol_q;
            hp_config_sel         <= hp_cfg_d; // [RL17]
            supply_volume_control <= svc_d;
            sda_oe                <= 1'b0; // [RL5] [RL11]
            rates_known           <= known_d; // [RL8]
        end
    end
endmodule // pcs_pin_sequencer

// >>> pcs_seq_monitor.sv
`timescale 1ns/1ns
module pcs_seq_monitor (
    // clock, reset, pins, configuration
    input wire       clk_sys,
    input wire       rstn,
    input wire       power_down_n,
    input wire       backend_error_n,
    input wire       mute_n,
    input wire       six_channel,
    input wire       reg_master_mute_n,
    // outputs
    input wire       valid,
    input wire       pll_osc_enable,
    input wire       bus_enable,
    input wire [7:0] pwm_run,
    input wire [1:0] hp_run,
    input wire [7:0] volume,
    input wire       supply_volume_control,
    input wire       sda_oe,
    input wire       rates_known
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    pd_clocks_off_a: assert property (!power_down_n |-> !pll_osc_enable)
        else $error("clock enable on in power-down");
    pd_hard_mute_a: assert property (!power_down_n |-> (volume | pwm_run) == 8'h00)
        else $error("volume or pwm active in power-down");
    pd_pins_low_a: assert property (!power_down_n |-> !valid && !supply_volume_control)
        else $error("valid or supply control high in power-down");
    pd_bus_off_a: assert property (!power_down_n |-> !bus_enable)
        else $error("bus enabled in power-down");
    sda_released_a: assert property (!sda_oe)
        else $error("sda driven");
    rate_first_a: assert property (valid |-> rates_known)
        else $error("valid before rates known");
    error_seen_a: assert property ((power_down_n && !backend_error_n) [*8] |-> ##[0:3] !valid)
        else $error("long error not taken");
    short_error_a: assert property (valid && backend_error_n ##1 !backend_error_n [*3]
        ##1 backend_error_n [*8] |-> valid)
        else $error("short error taken");
    err_all_stop_a: assert property (power_down_n && $fell(valid) && !six_channel
        |-> ##[0:3] pwm_run == 8'h00)
        else $error("channel running in eight-channel error");
    hp_excl_a: assert property (hp_run != 2'b00 |-> pwm_run[1:0] == 2'b00)
        else $error("speaker and headphone both on");
    mute_ramp_a: assert property ((!mute_n || !reg_master_mute_n) [*4] ##0 volume != 8'h00
        |=> volume < $past(volume))
        else $error("volume not ramping down in mute");
    cv_six_err: cover property ($fell(valid) && six_channel);
    cv_hp: cover property (hp_run == 2'b11);
    cv_muted: cover property (valid && volume == 8'h00);
endmodule // pcs_seq_monitor
bind pcs_pin_sequencer pcs_seq_monitor u_mon (.clk_sys, .rstn, .power_down_n, .backend_error_n,
    .mute_n, .six_channel, .reg_master_mute_n, .valid, .pll_osc_enable, .bus_enable, .pwm_run,
    .hp_run, .volume, .supply_volume_control, .sda_oe, .rates_known);

// >>> pcs_stage_model.sv
`timescale 1ns/1ns
module pcs_stage_model (
    // clock and fault line
    input  wire clk_sys,
    output reg  backend_error_n
);
    // line idles high; the stage pulls it only while reporting
    initial backend_error_n = 1'b1;
    task pulse(input integer n);
        begin
            backend_error_n = 1'b0;
            repeat (n) @(negedge clk_sys);
            backend_error_n = 1'b1;
        end
    endtask
endmodule // pcs_stage_model

// >>> testbench.sv
`timescale 1ns/1ns
module testbench;
    reg        clk_sys            = 1'b0;
    reg        rstn               = 1'b0;
    reg        power_down_n       = 1'b1;
    reg        headphone_select_n = 1'b1;
    reg        mute_n             = 1'b1;
    reg        six_channel        = 1'b0;
    reg        reg_master_mute_n  = 1'b1;
    reg  [7:0] chan_mute          = 8'h00;
    reg  [7:0] volume_cmd         = 8'h10;
    reg        supply_volume_control_enable        = 1'b1;
    wire       backend_error_n, valid, pll_osc_enable, bus_enable;
    wire       hp_config_sel, supply_volume_control, sda_oe, rates_known;
    wire [7:0] pwm_run, volume;
    wire [1:0] hp_run;
    integer    miscompares        = 0;
    integer    check_count        = 0;
    integer    i;
    pcs_stage_model stage (.clk_sys, .backend_error_n);
    pcs_pin_sequencer #(.ERR_WAIT_CYC(20), .RATE_CYC(8), .REINIT_CYC(8)) dut (.clk_sys, .rstn,
        .power_down_n, .backend_error_n, .headphone_select_n, .mute_n, .six_channel,
        .reg_master_mute_n, .chan_mute, .volume_cmd, .supply_volume_control_enable, .valid,
        .pll_osc_enable, .bus_enable, .pwm_run, .hp_run, .volume, .hp_config_sel,
        .supply_volume_control, .sda_oe, .rates_known);
    task chk(input [7:0] got, input [7:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task wt(input integer n);
        repeat (n) @(negedge clk_sys);
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task t_start;
        begin
            wt(60);
            chk({4'h0, pll_osc_enable, valid, rates_known, supply_volume_control}, 8'h0F);
            chk(pwm_run, 8'hFF);
            supply_volume_control_enable = 1'b0;
            wt(3);
            chk({7'h00, supply_volume_control}, 8'h00);
            supply_volume_control_enable = 1'b1;
            wt(3);
        end
    endtask
    task t_short;
        begin
            stage.pulse(3);
            wt(20);
            chk({7'h00, valid}, 8'h01);
        end
    endtask
    task t_error(input six, input [7:0] exp);
        begin
            six_channel = six;
            stage.pulse(10);
            wt(5);
            chk({7'h00, valid}, 8'h00);
            chk(pwm_run, exp);
            wt(60);
            chk({7'h00, valid}, 8'h01);
            chk(pwm_run, 8'hFF);
            six_channel = 1'b0;
        end
    endtask
    task t_mute;
        begin
            volume_cmd = 8'h20;
            for (i = 0; i < 2; i = i + 1) begin
                reg_master_mute_n = i[0];
                mute_n = ~i[0];
                wt(40);
                chk(volume | pwm_run, 8'h00);
                reg_master_mute_n = 1'b1;
                mute_n = 1'b1;
                wt(40);
                chk(volume, 8'h20);
            end
            chan_mute = 8'h04;
            wt(40);
            chk(pwm_run, 8'hFB);
            chk(volume, 8'h20);
            chan_mute = 8'h00;
            wt(4);
            chk(pwm_run, 8'hFF);
            volume_cmd = 8'h10;
            wt(20);
        end
    endtask
    task t_hp;
        begin
            headphone_select_n = 1'b0;
            wt(8);
            chk({7'h00, volume < 8'h10}, 8'h01);
            wt(60);
            chk({5'h00, hp_config_sel, hp_run}, 8'h07);
            chk(pwm_run, 8'hFC);
            headphone_select_n = 1'b1;
            six_channel = 1'b1;
            wt(4);
            mute_n = 1'b0;
            wt(40);
            mute_n = 1'b1;
            wt(60);
            chk({5'h00, hp_config_sel, hp_run}, 8'h00);
            chk(pwm_run, 8'hFF);
            six_channel = 1'b0;
        end
    endtask
    task t_pd;
        begin
            power_down_n = 1'b0;
            #5;
            chk({valid, pll_osc_enable, bus_enable, supply_volume_control, sda_oe, 3'h0}, 8'h00);
            chk(volume | pwm_run, 8'h00);
            wt(6);
            power_down_n = 1'b1;
            wt(60);
            chk({6'h00, valid, bus_enable}, 8'h03);
        end
    endtask
    initial forever #20 clk_sys = ~clk_sys;
    initial begin
        wt(12);
        rstn = 1'b1;
        t_start;
        t_short;
        t_error(1'b0, 8'h00);
        t_error(1'b1, 8'h30);
        t_mute;
        t_hp;
        t_pd;
        end_sim;
    end
    initial begin
        #100000;
        miscompares = miscompares + 1;
        end_sim;
    end
endmodule // testbench
